/* core/oc_cfg.svh */
`ifndef OC_CFG_SVH
`define OC_CFG_SVH

// clock rate in MHz
`define CLK_MHZ 50

// register offsets
`define ADDR_GEN_CTRL 8'h00
`define ADDR_DIAG_CTRL 8'h04
`define ADDR_GEN_STAT 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_CLR 8'h10
`define ADDR_IRQ_EN 8'h14
`define ADDR_DRV_STAT 8'h18

// general_control_one fields
`define GC_EN_BIT 0
`define GC_THR_LSB 1
`define GC_DIR_BIT 3
`define GC_RST 4'h0

// bridge_diag_control fields
`define BD_FILT_LSB 0
`define BD_CAP_BIT 2
`define BD_RST 3'h0

// general_status_reg fields
`define ST_OC_BIT 0
`define ST_CH_BIT 1
`define ST_GEF_BIT 2

// interrupt event bits
`define IRQ_W 3
`define IRQ_DET_BIT 0
`define IRQ_GONE_BIT 1
`define IRQ_TRIP_BIT 2

// filter times in us and their cycle counts
`define FILT_W 13
`define FILT_T0_US 6
`define FILT_T1_US 10
`define FILT_T2_US 50
`define FILT_T3_US 100
`define FILT_C0 (`FILT_T0_US * `CLK_MHZ)
`define FILT_C1 (`FILT_T1_US * `CLK_MHZ)
`define FILT_C2 (`FILT_T2_US * `CLK_MHZ)
`define FILT_C3 (`FILT_T3_US * `CLK_MHZ)

`endif

/* core/oc_pkg.sv */
package oc_pkg;

  // qualified state of the overcurrent filter
  typedef enum logic [1:0] {
    FLT_QUIET = 2'h1,
    FLT_ALERT = 2'h2
  } filt_state_t;

endpackage

/* core/oc_filter.sv */
`timescale 1ns/1ns
`include "oc_cfg.svh"
module oc_filter (
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // raw comparator level and filter length in cycles
  input wire logic raw,
  input wire logic [`FILT_W-1:0] limit,
  // qualified overcurrent level
  output logic qual
);

  oc_pkg::filt_state_t state_q;
  oc_pkg::filt_state_t state_d;
  logic [`FILT_W-1:0] cnt_q;
  logic [`FILT_W-1:0] cnt_d;

  // count cycles where the raw level disagrees with the state
  wire alert = (state_q == oc_pkg::FLT_ALERT);
  wire differ = alert ? !raw : raw;
  wire [`FILT_W-1:0] last = limit - `FILT_W'(1);
  // >= so a shortened filter takes effect at once
  wire expire = differ && (cnt_q >= last);
  assign cnt_d = (!differ || expire) ? '0 : cnt_q + `FILT_W'(1);
  assign qual = alert;

  // state flips only after a full unbroken run
  always_comb begin
    case (state_q)
      oc_pkg::FLT_QUIET: state_d = expire ? oc_pkg::FLT_ALERT : state_q;
      oc_pkg::FLT_ALERT: state_d = expire ? oc_pkg::FLT_QUIET : state_q;
      default: state_d = oc_pkg::FLT_QUIET;
    endcase
  end

  // counter and state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= oc_pkg::FLT_QUIET;
      cnt_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  restart_count_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !differ |=> cnt_q == '0)
    else $error("filter count not restarted");

  qualify_run_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !alert && raw && cnt_q == last |=> alert)
    else $error("full run did not qualify");

  early_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !alert && cnt_q < last && last != '0 |=> !alert)
    else $error("qualified before filter time");

endmodule

/* core/overcurrent_fault_response.sv */
`timescale 1ns/1ns
`include "oc_cfg.svh"
module overcurrent_fault_response #(
  parameter int unsigned FILT3_CYC = `FILT_C3
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // analog comparator results at the amplifier output
  input wire logic comp_hi,
  input wire logic comp_lo,
  // settings to the analog stage
  output logic [1:0] overcurrent_threshold_sel,
  output logic sense_direction_sel,
  output logic output_cap_range_sel,
  // gate driver control and flags
  output logic gates_off,
  output logic global_error,
  output logic irq
);

  // address match, used for every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // filter length per code; longest one is a parameter
  function automatic logic [`FILT_W-1:0] filt_len(input logic [1:0] s);
    case (s)
      2'h0: filt_len = `FILT_W'(`FILT_C0);
      2'h1: filt_len = `FILT_W'(`FILT_C1);
      2'h2: filt_len = `FILT_W'(`FILT_C2);
      default: filt_len = `FILT_W'(FILT3_CYC);
    endcase
  endfunction

  logic [3:0] gc_q;
  logic [3:0] gc_d;
  logic [2:0] bd_q;
  logic [2:0] bd_d;
  logic oc_q;
  logic oc_d;
  logic shut_q;
  logic shut_d;
  logic raw_q;
  logic raw_d;
  logic det_q;
  logic [`IRQ_W-1:0] ist_q;
  logic [`IRQ_W-1:0] ist_d;
  logic [`IRQ_W-1:0] ien_q;
  logic [`IRQ_W-1:0] ien_d;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic det;

  // register decode
  wire wr_gc = wr && hit(addr, `ADDR_GEN_CTRL);
  wire wr_bd = wr && hit(addr, `ADDR_DIAG_CTRL);
  wire wr_st = wr && hit(addr, `ADDR_GEN_STAT);
  wire wr_ic = wr && hit(addr, `ADDR_IRQ_CLR);
  wire wr_ie = wr && hit(addr, `ADDR_IRQ_EN);

  // control fields
  wire en = gc_q[`GC_EN_BIT];
  wire dir = gc_q[`GC_DIR_BIT];
  wire [1:0] fsel = bd_q[`BD_FILT_LSB +: 2];

  // any write to the status register is a clear request
  wire st_clr = wr_st;
  // any control write with the enable bit 0, whether or not it was set
  wire en_off = wr_gc && !wdata[`GC_EN_BIT];

  // comparator window: lower side counts only in bidirectional mode
  assign raw_d = comp_hi || (dir && comp_lo);

  // qualification filter
  oc_filter u_filter (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .raw(raw_q),
    .limit(filt_len(fsel)),
    .qual(det)
  );

  // events from the qualified level
  wire det_rise = det && !det_q;
  wire det_fall = !det && det_q;

  // status flag: set wins over any clear
  assign oc_d = det_rise ? 1'b1 :
                !en ? det :
                (oc_q && !(st_clr && !det));

  // forced-off: a new trip wins over a release in the same cycle
  assign shut_d = (en && det_rise) ||
                  (shut_q && !st_clr && !en_off);

  // register next values
  assign gc_d = wr_gc ? wdata[3:0] : gc_q;
  assign bd_d = wr_bd ? wdata[2:0] : bd_q;
  assign ien_d = wr_ie ? wdata[`IRQ_W-1:0] : ien_q;

  // sticky interrupt bits: event wins over clear
  wire [`IRQ_W-1:0] ev;
  assign ev[`IRQ_DET_BIT] = det_rise;
  assign ev[`IRQ_GONE_BIT] = det_fall;
  assign ev[`IRQ_TRIP_BIT] = en && det_rise;
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_ist
      assign ist_d[gi] = ev[gi] ||
                         (ist_q[gi] && !(wr_ic && wdata[gi]));
    end
  endgenerate

  // read mux; unmapped and write-only offsets read zero
  wire [7:0] st_word = {5'h0, oc_q, oc_q, oc_q};
  wire [7:0] drv_word = {5'h0, det, raw_q, shut_q};
  assign rdata_d = !rd ? 8'h00 :
    hit(addr, `ADDR_GEN_CTRL) ? {4'h0, gc_q} :
    hit(addr, `ADDR_DIAG_CTRL) ? {5'h0, bd_q} :
    hit(addr, `ADDR_GEN_STAT) ? st_word :
    hit(addr, `ADDR_IRQ_STAT) ? {5'h0, ist_q} :
    hit(addr, `ADDR_IRQ_EN) ? {5'h0, ien_q} :
    hit(addr, `ADDR_DRV_STAT) ? drv_word : 8'h00;

  // control registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gc_q <= `GC_RST;
      bd_q <= `BD_RST;
      ien_q <= '0;
    end else if (ce) begin
      gc_q <= gc_d;
      bd_q <= bd_d;
      ien_q <= ien_d;
    end
  end

  // supervision state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      raw_q <= 1'b0;
      det_q <= 1'b0;
      oc_q <= 1'b0;
      shut_q <= 1'b0;
    end else if (ce) begin
      raw_q <= raw_d;
      det_q <= det;
      oc_q <= oc_d;
      shut_q <= shut_d;
    end
  end

  // interrupts and read data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ist_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (ce) begin
      ist_q <= ist_d;
      irq_q <= |(ist_d & ien_d);
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign rdata = rdata_q;
  assign overcurrent_threshold_sel = gc_q[`GC_THR_LSB +: 2];
  assign sense_direction_sel = gc_q[`GC_DIR_BIT];
  assign output_cap_range_sel = bd_q[`BD_CAP_BIT];
  assign gates_off = shut_q;
  assign global_error = oc_q;
  assign irq = irq_q;

  // rule checks; every antecedent carries ce since ce low freezes all
  report_only_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && det_rise && !en && !shut_q |=> oc_q && global_error && !gates_off)
    else $error("report-only detection touched the drivers");

  self_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !en && !det && !det_rise |=> !oc_q)
    else $error("status did not clear itself");

  trip_off_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && en && det_rise |=> gates_off && oc_q)
    else $error("enabled detection did not force off");

  release_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && shut_q && (st_clr || en_off) && !(en && det_rise)
    |=> !gates_off)
    else $error("forced-off not released");

  latched_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && en && oc_q && (det || !st_clr) |=> oc_q)
    else $error("latched status lost");

  window_low_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && dir && comp_lo |=> raw_q)
    else $error("lower window side ignored");

  unidir_low_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !dir && comp_lo && !comp_hi |=> !raw_q)
    else $error("lower side used in unidirectional mode");

  thr_write_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && wr_gc |=> overcurrent_threshold_sel == $past(wdata[2:1]))
    else $error("threshold code not passed on");

  cap_write_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && wr_bd |=> output_cap_range_sel == $past(wdata[2]))
    else $error("cap range bit not passed on");

  irq_level_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce ##1 (ce && ist_q == $past(ist_d)) |-> irq == |(ist_q & ien_q))
    else $error("interrupt level wrong");

  read_data_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && rd && hit(addr, `ADDR_GEN_STAT) |=> rdata[0] == $past(oc_q))
    else $error("status read wrong");

  // ce low must freeze every register, outputs included
  freeze_all_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !ce |=> $stable(gc_q) && $stable(bd_q) && $stable(ien_q) &&
      $stable(oc_q) && $stable(shut_q) && $stable(ist_q) &&
      $stable(rdata) && $stable(irq))
    else $error("state moved while the clock enable was low");

  // shutdown off never forces the drivers
  drivers_kept_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !en && !shut_q |=> !gates_off)
    else $error("drivers forced off with shutdown disabled");

  // a new trip beats a release request in the same cycle
  trip_wins_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && en && det_rise && (st_clr || en_off) |=> gates_off)
    else $error("release beat a new trip");

  // forced-off holds until software releases it
  force_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && shut_q && !st_clr && !en_off |=> gates_off)
    else $error("forced-off dropped without a release");

  // with shutdown on, a clear while the fault is gone drops the flag
  latch_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && en && st_clr && !det |=> !oc_q)
    else $error("latched status kept after a valid clear");

  // read data only in the cycle after a read strobe
  read_idle_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !rd |=> rdata == 8'h00)
    else $error("read data outside a read cycle");

  // pending bits survive until software clears them
  irq_sticky_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && !wr_ic |=> (ist_q & $past(ist_q)) == $past(ist_q))
    else $error("pending interrupt bit lost");

  // each event lands in its pending bit, even beside a clear
  event_wins_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && det_rise |=> ist_q[`IRQ_DET_BIT])
    else $error("detect event not pending");

  trip_irq_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && en && det_rise |=> ist_q[`IRQ_TRIP_BIT])
    else $error("trip event not pending");

  gone_event_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && det_fall |=> ist_q[`IRQ_GONE_BIT])
    else $error("gone event not pending");

  // register fields read back and passed on
  dir_write_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && wr_gc |=> sense_direction_sel == $past(wdata[`GC_DIR_BIT]))
    else $error("direction bit not passed on");

  drv_read_a: assert property (
    @(posedge clock) disable iff (!nrst)
    ce && rd && hit(addr, `ADDR_DRV_STAT) |=>
      rdata[0] == $past(gates_off) && rdata[2] == $past(det))
    else $error("drive status read wrong");

  // main scenarios that the bench should reach
  trip_cover_c: cover property (
    @(posedge clock) disable iff (!nrst)
    en && det_rise ##1 gates_off);

  release_cover_c: cover property (
    @(posedge clock) disable iff (!nrst)
    gates_off && st_clr ##1 !gates_off);

  self_clear_cover_c: cover property (
    @(posedge clock) disable iff (!nrst)
    !en && oc_q && det_fall ##1 !oc_q);

  low_side_cover_c: cover property (
    @(posedge clock) disable iff (!nrst)
    dir && comp_lo && !comp_hi ##1 raw_q);

  latch_cover_c: cover property (
    @(posedge clock) disable iff (!nrst)
    en && oc_q && det_fall ##1 oc_q);

endmodule

/* test/sense_comparator_model.sv */
`timescale 1ns/1ns
module sense_comparator_model (
  // sense level in twentieths of supply
  input wire logic [4:0] level,
  // settings from the block
  input wire logic [1:0] overcurrent_threshold_sel,
  input wire logic sense_direction_sel,
  // comparator results
  output logic comp_hi,
  output logic comp_lo
);
  logic [4:0] half_w;
  logic [4:0] upper;
  logic [4:0] lower;
  // bidirectional half-window widths of 2, 4, 5 and 6
  assign half_w = (overcurrent_threshold_sel == 2'h0) ? 5'h02 :
                  (overcurrent_threshold_sel == 2'h1) ? 5'h04 :
                  (overcurrent_threshold_sel == 2'h2) ? 5'h05 : 5'h06;
  // unidirectional: half supply plus code tenths
  assign upper = sense_direction_sel ? 5'h0A + half_w :
                 5'h0A + {2'h0, overcurrent_threshold_sel, 1'h0};
  assign lower = 5'h0A - half_w;
  // strict compare, so a level on the threshold stays quiet
  assign comp_hi = level > upper;
  // low side runs in both modes; the block must mask it when unidirectional
  assign comp_lo = level < lower;
endmodule

/* test/overcurrent_fault_response_tb.sv */
`timescale 1ns/1ns
`include "oc_cfg.svh"
module overcurrent_fault_response_tb;
  localparam int N3 = 40;
  logic clock, nrst, ce, wr, rd, rd_d, comp_hi, comp_lo;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] thr_sel;
  logic dir_sel, cap_sel, gates_off, global_error, irq;
  logic [4:0] level;
  logic [7:0] exp_q[$];
  logic [7:0] adr_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int hw[4] = '{2, 4, 5, 6};
  int filt_cyc[4] = '{`FILT_C0, `FILT_C1, `FILT_C2, N3};
  int thr, lo, n;
  logic [7:0] ro_addr[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h20};

  overcurrent_fault_response #(.FILT3_CYC(N3)) overcurrent_fault_response_i (
    .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .comp_hi(comp_hi), .comp_lo(comp_lo),
    .overcurrent_threshold_sel(thr_sel), .sense_direction_sel(dir_sel),
    .output_cap_range_sel(cap_sel), .gates_off(gates_off),
    .global_error(global_error), .irq(irq));

  sense_comparator_model sense_comparator_model_i (
    .level(level), .overcurrent_threshold_sel(thr_sel),
    .sense_direction_sel(dir_sel), .comp_hi(comp_hi), .comp_lo(comp_lo));

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clock);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask

  // expectation is queued here and compared by the read monitor
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clock);
    rd <= 1'h0;
  endtask

  task automatic chk_out(input logic g, input logic e);
    @(negedge clock);
    chk("gates_off global_error", {6'h00, g, e},
        {6'h00, gates_off, global_error});
  endtask

  task automatic hold_level(input int v, input int c);
    @(posedge clock);
    level <= v[4:0];
    wait_cyc(c);
  endtask

  // settle a level for the short filter, then look at status and outputs
  task automatic probe(input int v, input logic set, input logic g);
    hold_level(v, N3 + 6);
    reg_rd(`ADDR_GEN_STAT, set ? 8'h07 : 8'h00);
    chk_out(g, set);
  endtask

  // read data stand only in the cycle after the strobe, zero elsewhere
  always @(posedge clock) rd_d <= rd;
  always @(negedge clock) begin
    if (rd_d === 1'h1 && exp_q.size() > 0) begin
      chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), rdata);
    end else begin
      chk("idle read data", 8'h00, rdata);
    end
  end

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // hang guard, far above the longest legal sequence
  initial begin
    #1200000;
    num_errors++;
    stop_test();
  end

  initial begin
    nrst = 1'h0;
    ce = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    level = 5'h0A;
    void'($urandom(32'hAC308BD4));
    wait_cyc(3);
    nrst <= 1'h1;
    // reset values, a read-only write and an unmapped place
    reg_wr(`ADDR_DRV_STAT, 8'hFF);
    foreach (ro_addr[i]) reg_rd(ro_addr[i], 8'h00);
    chk_out(1'h0, 1'h0);
    reg_wr(`ADDR_DIAG_CTRL, 8'h07);
    reg_rd(`ADDR_DIAG_CTRL, 8'h07);
    chk_out(1'h0, 1'h0);
    chk("cap select", 8'h01, {7'h00, cap_sel});
    // every threshold code in both directions, shutdown off
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 4; k++) begin
        thr = d ? 10 + hw[k] : 10 + 2 * k;
        lo = 10 - hw[k];
        reg_wr(`ADDR_GEN_CTRL, {4'h0, d[0], k[1:0], 1'h0});
        probe(thr, 1'h0, 1'h0);
        chk("thresh cfg", {5'h00, d[0], k[1:0]},
            {5'h00, dir_sel, thr_sel});
        probe(thr + 1 + $urandom_range(19 - thr),
              1'h1, 1'h0);
        probe(10, 1'h0, 1'h0);
        if (d == 0) begin
          probe(2, 1'h0, 1'h0);
        end else begin
          probe(lo, 1'h0, 1'h0);
          probe(lo - 1 - $urandom_range(lo - 1), 1'h1, 1'h0);
          probe(10, 1'h0, 1'h0);
        end
      end
    end
    // each filter time, with a restart on a short drop
    reg_wr(`ADDR_GEN_CTRL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      n = filt_cyc[c];
      reg_wr(`ADDR_DIAG_CTRL, {6'h00, c[1:0]});
      hold_level(15, n - 5);
      reg_rd(`ADDR_GEN_STAT, 8'h00);
      hold_level(2, 3);
      hold_level(15, n - 5);
      reg_rd(`ADDR_GEN_STAT, 8'h00);
      wait_cyc(11);
      reg_rd(`ADDR_GEN_STAT, 8'h07);
      hold_level(2, n + 6);
      reg_rd(`ADDR_GEN_STAT, 8'h00);
    end
    chk("cap select", 8'h00, {7'h00, cap_sel});
    // shutdown, latching and both ways of release
    reg_wr(`ADDR_IRQ_CLR, 8'h07);
    reg_rd(`ADDR_IRQ_STAT, 8'h00);
    reg_wr(`ADDR_IRQ_EN, 8'h05);
    reg_wr(`ADDR_GEN_CTRL, 8'h01);
    probe(15, 1'h1, 1'h1);
    chk("irq", 8'h01, {7'h00, irq});
    reg_rd(`ADDR_IRQ_STAT, 8'h05);
    reg_rd(`ADDR_DRV_STAT, 8'h07);
    probe(2, 1'h1, 1'h1);
    reg_wr(`ADDR_GEN_STAT, 8'h00);
    reg_rd(`ADDR_GEN_STAT, 8'h00);
    chk_out(1'h0, 1'h0);
    probe(15, 1'h1, 1'h1);
    reg_wr(`ADDR_GEN_STAT, 8'hFF);
    reg_rd(`ADDR_GEN_STAT, 8'h07);
    chk_out(1'h0, 1'h1);
    probe(2, 1'h1, 1'h0);
    reg_wr(`ADDR_GEN_STAT, 8'h00);
    reg_rd(`ADDR_GEN_STAT, 8'h00);
    probe(15, 1'h1, 1'h1);
    reg_wr(`ADDR_GEN_CTRL, 8'h00);
    reg_rd(`ADDR_GEN_STAT, 8'h07);
    chk_out(1'h0, 1'h1);
    probe(2, 1'h0, 1'h0);
    // masking and clearing the interrupt
    reg_wr(`ADDR_IRQ_EN, 8'h00);
    wait_cyc(1);
    chk_out(1'h0, 1'h0);
    chk("irq masked", 8'h00, {7'h00, irq});
    reg_wr(`ADDR_IRQ_CLR, 8'h07);
    reg_rd(`ADDR_IRQ_STAT, 8'h00);
    reg_wr(`ADDR_IRQ_EN, 8'h07);
    reg_rd(`ADDR_IRQ_EN, 8'h07);
    chk_out(1'h0, 1'h0);
    chk("irq cleared", 8'h00, {7'h00, irq});
    // clock enable low freezes the registers and the filter
    @(posedge clock);
    ce <= 1'h0;
    reg_wr(`ADDR_GEN_CTRL, 8'h0F);
    hold_level(20, N3 + 6);
    ce <= 1'h1;
    level <= 5'h0A;
    reg_rd(`ADDR_GEN_CTRL, 8'h00);
    reg_rd(`ADDR_GEN_STAT, 8'h00);
    chk_out(1'h0, 1'h0);
    chk("irq frozen", 8'h00, {7'h00, irq});
    stop_test();
  end
endmodule
